// [core/tmr_pwm_top.sv]
// Eight-bit timer with dual-slope PWM on two compare outputs and holding registers.
// Assumes AXI4-Lite on CLK_SYS; the oscillator pin is sampled as synchronous to CLK_SYS.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Waveform modes 1 and 5 count up to TOP then down to BOTTOM.
// - TOP is 0xFF or compare A, chosen by mode bit two.
// - Non-inverting clears on up-count match, sets on down; inverting opposite.
// - Output action two gives non-inverted PWM, three inverted.
// - Counter holds TOP for one timer tick, then counts down.
// - Overflow flag sets whenever the counter reaches BOTTOM.
// - Period is twice TOP, 510 prescaled ticks at TOP 0xFF; prescale 1,8,32,64,128,256,1024.
// - Compare at BOTTOM gives steady low, at MAX steady high; inverted complements.
// - Output is forced to its symmetric level at BOTTOM without a match.
// - Compare level reaches the pin only when its direction is output.
// - Asynchronous writes go to a holding register, latched after two oscillator edges.
// - Five registers each have their own holding register.
// - Compare matches are suppressed while counter or compare transfer pends.
// - Wake request starts on the next timer tick after the condition.
// - Counter reads in asynchronous mode come from a copy taken each oscillator edge.
// - Asynchronous flags take three system cycles; pins change on timer ticks.
// - Timer runs from the system clock unless asynchronous select is set.
// - Output action zero leaves normal port operation.
module tmr_pwm_top
    import tmr_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // AXI4-Lite write
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Oscillator pin
    input wire logic ASYNC_CLOCK_PIN,
    // Compare output pins
    output logic PIN_A_O,
    output logic PIN_A_OE_N,
    output logic PIN_B_O,
    output logic PIN_B_OE_N,
    // Wake request
    output logic WAKE_REQ
);
    typedef struct packed {
        wr_state_t wr_st;
        logic aw_ready;
        logic w_ready;
        logic b_valid;
        logic [1:0] b_resp;
        logic ar_ready;
        logic r_valid;
        logic [31:0] r_data;
        logic [1:0] r_resp;
        logic async_sel;
        logic [1:0] pin_dir;
        logic [1:0] port_data;
        logic [2:0] irq_en;
        logic [2:0] flags;
        logic [8:0] evt_pipe;
        logic osc_prev;
        logic [9:0] presc;
        logic [7:0] cnt;
        logic down;
        logic [1:0] cmp_out;
        logic [7:0] cnt_copy;
        logic [1:0] pin_o;
        logic [1:0] pin_oe_n;
        logic wake;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic [NUM_HOLD-1:0] hold_wr;
    logic [NUM_HOLD-1:0] hold_busy;
    logic [NUM_HOLD-1:0] hold_load;
    logic [7:0] hold_dest [NUM_HOLD];
    logic wr_fire;
    logic osc_edge;
    logic tick;
    logic [2:0] mode;
    logic pc_mode;
    logic [7:0] top;
    logic [7:0] cmp [2];
    logic [1:0] act [2];
    logic [1:0] match;
    logic [2:0] evt;

    assign wr_fire = (s_r.wr_st == WR_TAKE) && S_AXI_WSTRB[0];
    assign osc_edge = ASYNC_CLOCK_PIN && !s_r.osc_prev;
    assign mode = {hold_dest[HX_CTRL_B][WM_HI_BIT], hold_dest[HX_CTRL_A][1:0]};
    assign pc_mode = (mode == WM_PC_FIXED) || (mode == WM_PC_CMPA);
    assign top = mode[2] ? hold_dest[HX_CMP_A] : CNT_MAX;
    assign cmp[0] = hold_dest[HX_CMP_A];
    assign cmp[1] = hold_dest[HX_CMP_B];
    assign act[0] = hold_dest[HX_CTRL_A][ACT_A_LSB +: 2];
    assign act[1] = hold_dest[HX_CTRL_A][ACT_B_LSB +: 2];

    // Slow rate is a one-cycle enable from the prescaler
    always_comb begin
        logic src;
        logic [9:0] m;
        src = s_r.async_sel ? osc_edge : 1'b1;
        m = presc_mask(hold_dest[HX_CTRL_B][2:0]);
        tick = src && (hold_dest[HX_CTRL_B][2:0] != 3'd0)
               && ((s_r.presc & m) == m);
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_HOLD; gi++) begin : g_hold
            assign hold_wr[gi] = wr_fire && (S_AXI_AWADDR == HOLD_OFS[gi]);
            tmr_hold_reg u_hold (
                .clk(CLK_SYS),
                .rst(SYS_RST),
                .wr_en(hold_wr[gi]),
                .wr_data(S_AXI_WDATA[7:0] & HOLD_MASK[gi]),
                .async_mode(s_r.async_sel),
                .osc_edge(osc_edge),
                .busy(hold_busy[gi]),
                .load(hold_load[gi]),
                .dest(hold_dest[gi])
            );
        end
        for (gi = 0; gi < 2; gi++) begin : g_match
            // Matches are unreliable while a new value is in flight
            assign match[gi] = tick && (s_r.cnt == cmp[gi]) && !hold_busy[HX_COUNTER]
                               && !hold_busy[HX_CMP_A + gi];
        end
    endgenerate

    always_comb begin
        logic [7:0] rd;
        logic rd_ok;
        logic [2:0] flg_set;
        logic [2:0] flg_clr;
        rd = 8'h00;
        rd_ok = 1'b1;
        flg_set = 3'b000;
        flg_clr = 3'b000;
        s_nxt = s_r;
        s_nxt.osc_prev = ASYNC_CLOCK_PIN;
        evt = {match, 1'b0};

        // Write channel: both address and data before the response
        s_nxt.aw_ready = 1'b0;
        s_nxt.w_ready = 1'b0;
        case (s_r.wr_st)
            WR_IDLE: begin
                if (S_AXI_AWVALID && S_AXI_WVALID) begin
                    s_nxt.aw_ready = 1'b1;
                    s_nxt.w_ready = 1'b1;
                    s_nxt.wr_st = WR_TAKE;
                end
            end
            WR_TAKE: begin
                s_nxt.b_valid = 1'b1;
                s_nxt.b_resp = RESP_OKAY;
                if (S_AXI_AWADDR > OFS_PIN_CTRL || S_AXI_AWADDR[1:0] != 2'b00) begin
                    s_nxt.b_resp = RESP_SLVERR;
                end
                if (wr_fire) begin
                    case (S_AXI_AWADDR)
                        OFS_ASYNC_STATUS: s_nxt.async_sel = S_AXI_WDATA[ASYNC_SEL_BIT];
                        OFS_FLAGS: flg_clr = S_AXI_WDATA[2:0];
                        OFS_IRQ_EN: s_nxt.irq_en = S_AXI_WDATA[2:0];
                        OFS_PIN_CTRL: begin
                            s_nxt.pin_dir = S_AXI_WDATA[1:0];
                            s_nxt.port_data = S_AXI_WDATA[3:2];
                        end
                        default: ;
                    endcase
                end
                s_nxt.wr_st = WR_RESP;
            end
            WR_RESP: begin
                if (S_AXI_BREADY) begin
                    s_nxt.b_valid = 1'b0;
                    s_nxt.wr_st = WR_IDLE;
                end
            end
            default: s_nxt.wr_st = WR_IDLE;
        endcase

        // Read channel
        rd_ok = 1'b1;
        case (S_AXI_ARADDR)
            OFS_CTRL_A: rd = hold_dest[HX_CTRL_A];
            OFS_CTRL_B: rd = hold_dest[HX_CTRL_B];
            OFS_COUNTER: rd = s_r.async_sel ? s_r.cnt_copy : s_r.cnt;
            OFS_CMP_A: rd = hold_dest[HX_CMP_A];
            OFS_CMP_B: rd = hold_dest[HX_CMP_B];
            OFS_ASYNC_STATUS: rd = {2'b00, s_r.async_sel, hold_busy};
            OFS_FLAGS: rd = {5'd0, s_r.flags};
            OFS_IRQ_EN: rd = {5'd0, s_r.irq_en};
            OFS_PIN_CTRL: rd = {4'd0, s_r.port_data, s_r.pin_dir};
            default: begin
                rd = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
        s_nxt.ar_ready = 1'b0;
        if (s_r.ar_ready) begin
            s_nxt.r_valid = 1'b1;
            s_nxt.r_data = {24'h00_0000, rd};
            s_nxt.r_resp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_r.r_valid) begin
            if (S_AXI_RREADY) begin
                s_nxt.r_valid = 1'b0;
            end
        end else if (S_AXI_ARVALID) begin
            s_nxt.ar_ready = 1'b1;
        end

        // Prescaler and counter
        if (s_r.async_sel ? osc_edge : 1'b1) begin
            s_nxt.presc = s_r.presc + 10'd1;
        end
        if (tick) begin
            if (pc_mode) begin
                if (!s_r.down) begin
                    if (s_r.cnt == top) begin
                        s_nxt.cnt = top - 8'd1;
                        s_nxt.down = 1'b1;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 8'd1;
                    end
                end else if (s_r.cnt == CNT_BOTTOM) begin
                    s_nxt.cnt = s_r.cnt + 8'd1;
                    s_nxt.down = 1'b0;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'd1;
                end
            end else begin
                s_nxt.cnt = s_r.cnt + 8'd1;
                s_nxt.down = 1'b0;
            end
            evt[FLG_OVF] = (s_nxt.cnt == CNT_BOTTOM) && (s_r.cnt != CNT_BOTTOM);
        end
        if (hold_load[HX_COUNTER]) begin
            s_nxt.cnt = hold_dest[HX_COUNTER];
        end
        if (osc_edge) begin
            s_nxt.cnt_copy = s_r.cnt;
        end

        // Compare outputs change only on timer ticks
        for (int i = 0; i < 2; i++) begin
            if (tick && pc_mode && act[i][1]) begin
                if (s_r.cnt == CNT_BOTTOM) begin
                    // Symmetric level at BOTTOM, also covers a missed up-count match
                    s_nxt.cmp_out[i] = (cmp[i] != CNT_BOTTOM) ^ act[i][0];
                end else if (match[i]) begin
                    // Match at TOP acts as down-count match: MAX stays high
                    s_nxt.cmp_out[i] = (!s_r.down && s_r.cnt != top)
                                       ? act[i][0] : !act[i][0];
                end
            end else if (match[i] && !pc_mode) begin
                case (act[i])
                    ACT_TOGGLE: s_nxt.cmp_out[i] = !s_r.cmp_out[i];
                    ACT_PWM_NONINV: s_nxt.cmp_out[i] = 1'b0;
                    ACT_PWM_INV: s_nxt.cmp_out[i] = 1'b1;
                    default: ;
                endcase
            end
            s_nxt.pin_o[i] = (act[i] == ACT_OFF) ? s_r.port_data[i] : s_r.cmp_out[i];
            s_nxt.pin_oe_n[i] = !s_r.pin_dir[i];
        end

        // Flags; asynchronous events cross a three-cycle pipeline, set beats clear
        s_nxt.evt_pipe = {s_r.evt_pipe[5:0], evt};
        flg_set = s_r.async_sel ? s_r.evt_pipe[8:6] : evt;
        s_nxt.flags = (s_r.flags & ~flg_clr) | flg_set;

        // Wake request raised on the timer tick after the condition
        if ((s_r.flags & s_r.irq_en) == 3'b000) begin
            s_nxt.wake = 1'b0;
        end else if (tick) begin
            s_nxt.wake = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_r <= '0;
            s_r.pin_oe_n <= PIN_OE_N_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign S_AXI_AWREADY = s_r.aw_ready;
    assign S_AXI_WREADY = s_r.w_ready;
    assign S_AXI_BVALID = s_r.b_valid;
    assign S_AXI_BRESP = s_r.b_resp;
    assign S_AXI_ARREADY = s_r.ar_ready;
    assign S_AXI_RVALID = s_r.r_valid;
    assign S_AXI_RDATA = s_r.r_data;
    assign S_AXI_RRESP = s_r.r_resp;
    assign PIN_A_O = s_r.pin_o[0];
    assign PIN_B_O = s_r.pin_o[1];
    assign PIN_A_OE_N = s_r.pin_oe_n[0];
    assign PIN_B_OE_N = s_r.pin_oe_n[1];
    assign WAKE_REQ = s_r.wake;

    AST_PC_TOP_REVERSE: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (tick && pc_mode && !s_r.down && s_r.cnt == top && !hold_load[HX_COUNTER])
            |=> (s_r.down && s_r.cnt == $past(top) - 8'd1))
        else $error("counter did not turn down after TOP");

    AST_PC_BOTTOM_REVERSE: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (tick && pc_mode && s_r.down && s_r.cnt == CNT_BOTTOM && !hold_load[HX_COUNTER])
            |=> (!s_r.down && s_r.cnt == 8'd1))
        else $error("counter did not turn up after BOTTOM");

    AST_TOP_FROM_CMP_A: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (mode == WM_PC_CMPA) |-> (top == hold_dest[HX_CMP_A]))
        else $error("TOP not taken from compare A");

    AST_OVF_SYNC_MODE: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (evt[FLG_OVF] && !s_r.async_sel) |=> s_r.flags[FLG_OVF])
        else $error("overflow flag missed at BOTTOM");

    AST_FLAG_SYNC_DELAY: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (evt[FLG_OVF] && s_r.async_sel) ##1 s_r.async_sel [*3] |=> s_r.flags[FLG_OVF])
        else $error("asynchronous overflow flag not set after three cycles");

    AST_MATCH_SUPPRESSED: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (hold_busy[HX_COUNTER] || hold_busy[HX_CMP_A]) |-> !match[0])
        else $error("compare match during pending transfer");

    AST_PIN_RELEASED: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !s_r.pin_dir[0] |=> PIN_A_OE_N)
        else $error("pin driven while direction is input");

    AST_PORT_DATA_ON_OFF: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (act[0] == ACT_OFF) |=> (PIN_A_O == $past(s_r.port_data[0])))
        else $error("compare output reached pin while disconnected");

    AST_COPY_HELD: assert property (
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !osc_edge |=> $stable(s_r.cnt_copy))
        else $error("counter copy changed without oscillator edge");
endmodule
`default_nettype wire

// [inc/tmr_pkg.sv]
// Constants, register map and field layout for the dual-slope PWM timer.
// Assumes an AXI4-Lite master on CLK_SYS and an oscillator pin sampled on CLK_SYS.
package tmr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_COUNTER = 8'h08;
    localparam logic [7:0] OFS_CMP_A = 8'h0C;
    localparam logic [7:0] OFS_CMP_B = 8'h10;
    localparam logic [7:0] OFS_ASYNC_STATUS = 8'h14;
    localparam logic [7:0] OFS_FLAGS = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
    localparam logic [7:0] OFS_PIN_CTRL = 8'h20;

    // Holding-register slots, one per asynchronously written register
    localparam int NUM_HOLD = 5;
    localparam int HX_CTRL_A = 0;
    localparam int HX_CTRL_B = 1;
    localparam int HX_COUNTER = 2;
    localparam int HX_CMP_A = 3;
    localparam int HX_CMP_B = 4;
    localparam logic [7:0] HOLD_OFS [NUM_HOLD] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_COUNTER,
                                                    OFS_CMP_A, OFS_CMP_B};
    // Writable bits; reserved bits read as zero
    localparam logic [7:0] HOLD_MASK [NUM_HOLD] = '{8'hF3, 8'h0F, 8'hFF, 8'hFF, 8'hFF};

    // Field positions
    localparam int ACT_A_LSB = 6;
    localparam int ACT_B_LSB = 4;
    localparam int WM_HI_BIT = 3;
    localparam int ASYNC_SEL_BIT = 5;
    localparam int FLG_OVF = 0;
    localparam int FLG_CMP_A = 1;
    localparam int FLG_CMP_B = 2;

    // Modes and actions
    localparam logic [2:0] WM_NORMAL = 3'd0;
    localparam logic [2:0] WM_PC_FIXED = 3'd1;
    localparam logic [2:0] WM_PC_CMPA = 3'd5;
    localparam logic [1:0] ACT_OFF = 2'd0;
    localparam logic [1:0] ACT_TOGGLE = 2'd1;
    localparam logic [1:0] ACT_PWM_NONINV = 2'd2;
    localparam logic [1:0] ACT_PWM_INV = 2'd3;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;

    // Timing
    localparam int OSC_EDGES_TO_LATCH = 2;
    localparam int FLAG_SYNC_CYCLES = 3;
    localparam int PC_PERIOD_TICKS = 510;

    // Reset values
    localparam logic [1:0] PIN_OE_N_RST = 2'b11;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_TAKE = 2'b01,
        WR_RESP = 2'b11
    } wr_state_t;

    // Prescaler mask: tick when all masked bits are one; sel 0 stops the timer
    function automatic logic [9:0] presc_mask(input logic [2:0] sel);
        logic [9:0] m;
        m = 10'h000;
        case (sel)
            3'd1: m = 10'h000;
            3'd2: m = 10'h007;
            3'd3: m = 10'h01F;
            3'd4: m = 10'h03F;
            3'd5: m = 10'h07F;
            3'd6: m = 10'h0FF;
            3'd7: m = 10'h3FF;
            default: m = 10'h000;
        endcase
        return m;
    endfunction
endpackage

// [core/tmr_hold_reg.sv]
// One holding register with its transfer into the timer domain.
// Assumes osc_edge is a one-cycle pulse per rising edge of the oscillator pin.
`timescale 1ns/10ps
`default_nettype none
module tmr_hold_reg
    import tmr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Software write
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Timer source
    input wire logic async_mode,
    input wire logic osc_edge,
    // Destination
    output logic busy,
    output logic load,
    output logic [7:0] dest
);
    typedef struct packed {
        logic [7:0] hold;
        logic [7:0] dest;
        logic [1:0] edges;
        logic busy;
        logic load;
    } hold_t;

    hold_t s_r;
    hold_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.load = 1'b0;
        if (wr_en) begin
            s_nxt.hold = wr_data;
            s_nxt.edges = 2'd0;
            if (async_mode) begin
                s_nxt.busy = 1'b1;
            end else begin
                s_nxt.dest = wr_data;
                s_nxt.load = 1'b1;
                s_nxt.busy = 1'b0;
            end
        end else if (s_r.busy && osc_edge) begin
            s_nxt.edges = s_r.edges + 2'd1;
            if (s_r.edges == 2'(OSC_EDGES_TO_LATCH - 1)) begin
                s_nxt.dest = s_r.hold;
                s_nxt.load = 1'b1;
                s_nxt.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign load = s_r.load;
    assign dest = s_r.dest;

    AST_LATCH_ON_SECOND_EDGE: assert property (
        @(posedge clk) disable iff (rst)
        (s_r.busy && osc_edge && s_r.edges == 2'd1 && !wr_en)
            |=> (!s_r.busy && s_r.load && s_r.dest == $past(s_r.hold)))
        else $error("held value not latched on second oscillator edge");

    AST_BUSY_ON_ASYNC_WRITE: assert property (
        @(posedge clk) disable iff (rst)
        (wr_en && async_mode) |=> (s_r.busy && !s_r.load) [*1] ##1 1)
        else $error("busy flag not raised by asynchronous write");
endmodule
`default_nettype wire

// [sim/osc_model.sv]
// Crystal model at the oscillator pin: free-running, one rising edge per 32 system cycles.
// Assumes clk is the system clock; rises counts the rising edges for the bench.
`timescale 1ns/10ps
`default_nettype none
module osc_model (
    // System clock
    input wire logic clk,
    // Pin and edge count
    output logic pin,
    output var int rises
);
    int t;
    // Level follows the count alone, so the pin has a single driver
    always @(posedge clk) begin // Far slower than a quarter of clk
        t <= t + 1;
        pin <= (t % 32 >= 15) && (t % 32 != 31);
        if (t % 32 == 15) rises <= rises + 1;
    end
endmodule
`default_nettype wire

// [sim/async_timer_phase_pwm_tb.sv]
// Bench for the dual-slope PWM timer: bus master, pin widths and holding-register checks.
// Assumes osc_model drives the oscillator pin; the bench masters AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module async_timer_phase_pwm_tb
    import tmr_pkg::*;
;
    logic CLK_SYS, SYS_RST, ASYNC_CLOCK_PIN, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pa, pa_oe_n, pb, pb_oe_n, wake;
    logic [7:0] addr, d, e;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, r;
    int errors, compares, rises, k, h, l;
    tmr_pwm_top dut_u (.CLK_SYS, .SYS_RST, .S_AXI_AWADDR(addr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(addr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .ASYNC_CLOCK_PIN, .PIN_A_O(pa), .PIN_A_OE_N(pa_oe_n), .PIN_B_O(pb), .PIN_B_OE_N(pb_oe_n),
        .WAKE_REQ(wake));
    osc_model osc_u (.clk(CLK_SYS), .pin(ASYNC_CLOCK_PIN), .rises);
    initial begin
        CLK_SYS = 1'b0;
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end
    initial begin
        {SYS_RST, awvalid, wvalid, bready, arvalid, rready} = 6'b10_0000;
        {addr, wdata} = '0;
        repeat (5) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        t_reset();
        t_pwm();
        t_extreme();
        t_async();
        close_out();
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) errors++;
        if (seen !== want) $display("FAIL t=%0t seen %0h want %0h", $time, seen, want);
    endtask
    // One access; each channel is held until its own ready, answer waited on
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] v);
        int n = 0;
        @(posedge CLK_SYS);
        addr <= a;
        wdata <= {24'h00_0000, v};
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        do begin
            @(posedge CLK_SYS);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
        end while (!(wr ? bvalid : rvalid) && n < 64);
        bready <= 1'b0;
        rready <= 1'b0;
        r = wr ? bresp : rresp;
        d = rdata[7:0];
        chk(n < 64, 1'b1);
        if (n >= 64) close_out();
    endtask
    task automatic span(input logic v, output int c);
        for (c = 0; pb === v && c < 1500; c++) @(posedge CLK_SYS);
    endtask
    // Skips one partial period so a mode change cannot skew the widths
    task automatic meas();
        span(1'b1, h);
        span(1'b0, h);
        span(1'b1, h);
        span(1'b0, l);
    endtask
    task automatic t_reset();
        chk({pa, pa_oe_n, pb_oe_n}, 3'b011);
        acc(1'b1, OFS_PIN_CTRL, 8'h05);
        chk(r, RESP_OKAY);
        acc(1'b0, 8'h24, 8'h00);
        chk(r, RESP_SLVERR);
        chk({pa, pa_oe_n, pb_oe_n}, 3'b101);
        $display("reset and port test done");
    endtask
    task automatic t_pwm();
        acc(1'b1, OFS_CMP_B, 8'h40);
        acc(1'b1, OFS_CTRL_B, 8'h01);
        for (int a = 2; a < 4; a++) begin
            acc(1'b1, OFS_CTRL_A, {2'b00, a[1:0], 4'h1});
            meas();
            chk(h + l, PC_PERIOD_TICKS);
            chk(h, a == 2 ? 128 : 382);
        end
        acc(1'b0, OFS_FLAGS, 8'h00);
        chk(d[FLG_OVF], 1'b1);
        acc(1'b1, OFS_CMP_A, 8'h80);
        acc(1'b1, OFS_CMP_B, 8'h20);
        acc(1'b1, OFS_CTRL_B, 8'h09);
        meas();
        chk(h + l, 256);
        chk(h, 192);
        $display("phase-correct test done");
    endtask
    task automatic t_extreme();
        acc(1'b1, OFS_CTRL_B, 8'h01);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, OFS_CTRL_A, {2'b00, 2'b10 + i[1], 4'h1});
            acc(1'b1, OFS_CMP_B, i[0] ? 8'hFF : 8'h00);
            repeat (600) @(posedge CLK_SYS);
            span(i[0] ^ i[1], h);
            chk(h, 1500);
        end
        $display("extreme compare test done");
    endtask
    // Waits for the next oscillator rise; a missing rise counts as a mismatch
    task automatic osc_wait();
        k = rises;
        for (int i = 0; i < 40 && rises == k; i++) @(posedge CLK_SYS);
        chk(rises != k, 1'b1);
    endtask
    task automatic t_async();
        acc(1'b1, OFS_IRQ_EN, 8'h00);
        acc(1'b1, OFS_ASYNC_STATUS, 8'h20);
        osc_wait();
        k = rises;
        acc(1'b1, OFS_CMP_B, 8'h10);
        acc(1'b1, OFS_COUNTER, 8'h05);
        acc(1'b0, OFS_ASYNC_STATUS, 8'h00);
        chk(d, 8'h34);
        for (int i = 0; i < 40 && d[4:0] != 5'h00; i++) begin
            acc(1'b0, OFS_ASYNC_STATUS, 8'h00);
        end
        chk(d[4:0], 5'h00);
        chk(rises - k, 2);
        acc(1'b0, OFS_COUNTER, 8'h00);
        e = d;
        acc(1'b0, OFS_COUNTER, 8'h00);
        chk(d, e);
        // Copy shows the loaded value only after the next oscillator rise
        osc_wait();
        acc(1'b0, OFS_COUNTER, 8'h00);
        chk(d, 8'h05);
        acc(1'b1, OFS_IRQ_EN, 8'h01);
        chk(wake, 1'b0);
        osc_wait();
        repeat (2) @(posedge CLK_SYS);
        chk(wake, 1'b1);
        acc(1'b1, OFS_FLAGS, 8'h07);
        @(posedge CLK_SYS);
        chk(wake, 1'b0);
        $display("async test done");
    endtask
    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
endmodule
`default_nettype wire
